/* design/sssc_defines.vh */
// Purpose: Shared constants for the safety switch start control
// Assumes: 100 MHz system clock
// Notes:   Start times in ms, cycle counts derived from them; pulse window given directly in cycles
`ifndef SSSC_DEFINES_VH
`define SSSC_DEFINES_VH

`define SSSC_CLK_HZ           100000000
`define SSSC_START_MIN_MS     100
`define SSSC_START_MAX_MS     2000
`define SSSC_MS_CYCLES        (`SSSC_CLK_HZ / 1000)
`define SSSC_START_MIN_CYC    (`SSSC_START_MIN_MS * `SSSC_MS_CYCLES)
`define SSSC_START_MAX_CYC    (`SSSC_START_MAX_MS * `SSSC_MS_CYCLES)
`define SSSC_PULSE_CNT_W      8
`define SSSC_PULSE_SEEN_MIN   8'h03
`define SSSC_PULSE_WIN_CYC    200000
`define SSSC_ST_IDLE          2'h0
`define SSSC_ST_ARMED         2'h1
`define SSSC_ST_ON            2'h2

`endif

/* design/sssc_sync.v */
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Single clock domain
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module sssc_sync #(
	parameter W = 1
) (
	// Clock and reset
	input  wire         sys_clk,
	input  wire         reset,
	// Data
	input  wire [W-1:0] din,
	output reg  [W-1:0] dout
);
	reg [W-1:0] stage1;

	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			stage1 <= {W{1'b0}};
			dout   <= {W{1'b0}};
		end else begin
			stage1 <= din;
			dout   <= stage1;
		end
	end
endmodule

/* design/sssc_start_ctrl.v */
// Purpose: Startup selection, start pulse timing and safety output enable
// Assumes: Actuator detection comes from the coding logic on the same clock
// Notes:   Test pulses are made here on both channels; channel A loopback allows autostart only with 3 pulses per window, not the default 2
`timescale 1ns/1ps
`include "sssc_defines.vh"
module sssc_start_ctrl #(
	parameter START_MIN_CYC = `SSSC_START_MIN_CYC,
	parameter START_MAX_CYC = `SSSC_START_MAX_CYC,
	parameter PULSE_WIN_CYC = `SSSC_PULSE_WIN_CYC,
	parameter TEST_PERIOD   = 100000
) (
	// Clock and reset
	input  wire sys_clk,
	input  wire reset,
	// Actuator status from coding logic
	input  wire actuator_in_range,
	input  wire actuator_code_valid,
	// Pins
	input  wire start_pin,
	input  wire safety_in_chan_a,
	input  wire safety_in_chan_b,
	// Actuator link
	output reg  actuator_power_en,
	output reg  actuator_data_en,
	// Outputs
	output reg  safety_out_chan_a,
	output reg  safety_out_chan_b,
	output reg  diag_signal_out,
	output reg  auto_mode
);

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	// One place for the on-state decode, used by mode and outputs
	function is_on;
		input [1:0] st;
		begin
			is_on = (st == `SSSC_ST_ON);
		end
	endfunction

	reg  [1:0] state;
	reg  [1:0] next_state;

	// ------------------------------------------------------------
	// Input synchronisation
	// ------------------------------------------------------------
	wire [2:0] pins_s;
	wire       start_s = pins_s[0];
	wire       in_a_s  = pins_s[1];
	wire       in_b_s  = pins_s[2];

	sssc_sync #(.W(3)) u_sync (
		.sys_clk (sys_clk),
		.reset   (reset),
		.din     ({safety_in_chan_b, safety_in_chan_a, start_pin}),
		.dout    (pins_s)
	);

	// ------------------------------------------------------------
	// Test pulse generator
	// ------------------------------------------------------------
	// Short low pulse on enabled outputs; also the loopback signature
	reg  [31:0] test_cnt;
	reg         test_low;
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			test_cnt <= 32'h0;
			test_low <= 1'b0;
		end else if (test_cnt == TEST_PERIOD - 1) begin
			test_cnt <= 32'h0;
			test_low <= 1'b1;
		end else begin
			test_cnt <= test_cnt + 32'h1;
			if (test_cnt == 32'h3)
				test_low <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Startup mode detection
	// ------------------------------------------------------------
	// Loopback seen as start input dipping while channel A pulses low
	reg                          start_d;
	reg                          win_on;
	reg  [31:0]                  win_cnt;
	reg  [`SSSC_PULSE_CNT_W-1:0] hit_cnt;
	wire match = test_low & ~start_s & start_d;

	// Outputs that are off send no pulses back, so only windows spent fully on
	// decide; a wiring change made while off shows once the outputs are on again
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			start_d   <= 1'b0;
			win_on    <= 1'b0;
			win_cnt   <= 32'h0;
			hit_cnt   <= {`SSSC_PULSE_CNT_W{1'b0}};
			auto_mode <= 1'b0;
		end else begin
			start_d <= start_s;
			if (win_cnt == PULSE_WIN_CYC - 1) begin
				win_cnt <= 32'h0;
				win_on  <= is_on(state);
				if (win_on && is_on(state))
					auto_mode <= (hit_cnt >= `SSSC_PULSE_SEEN_MIN);
				hit_cnt <= {`SSSC_PULSE_CNT_W{1'b0}};
			end else begin
				win_cnt <= win_cnt + 32'h1;
				if (!is_on(state))
					win_on <= 1'b0;
				if (match && hit_cnt != {`SSSC_PULSE_CNT_W{1'b1}})
					hit_cnt <= hit_cnt + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Start pulse timing
	// ------------------------------------------------------------
	reg  [31:0] high_cnt;
	wire        fall = start_d & ~start_s;
	wire        pulse_ok = (high_cnt >= START_MIN_CYC) && (high_cnt <= START_MAX_CYC);
	always @(posedge sys_clk or posedge reset) begin
		if (reset)
			high_cnt <= 32'h0;
		else if (!start_s)
			high_cnt <= 32'h0;
		else if (high_cnt <= START_MAX_CYC)
			high_cnt <= high_cnt + 32'h1;
	end

	// A press must begin after arming, so a button held through arming never starts
	reg start_rose;
	always @(posedge sys_clk or posedge reset) begin
		if (reset)
			start_rose <= 1'b0;
		else if (state == `SSSC_ST_ARMED && start_s && !start_d)
			start_rose <= 1'b1;
		else if (state != `SSSC_ST_ARMED)
			start_rose <= 1'b0;
	end

	wire start_cmd = fall & pulse_ok & start_rose & ~auto_mode;

	// ------------------------------------------------------------
	// Output enable state machine
	// ------------------------------------------------------------
	wire chain_ok = in_a_s & in_b_s;
	wire act_ok   = actuator_in_range & actuator_code_valid;
	always @* begin
		next_state = state;
		case (state)
			`SSSC_ST_IDLE: begin
				if (act_ok && chain_ok)
					next_state = auto_mode ? `SSSC_ST_ON : `SSSC_ST_ARMED;
			end
			`SSSC_ST_ARMED: begin
				if (!act_ok || !chain_ok)
					next_state = `SSSC_ST_IDLE;
				else if (auto_mode)
					next_state = `SSSC_ST_ON;
				else if (start_cmd)
					next_state = `SSSC_ST_ON;
			end
			`SSSC_ST_ON: begin
				if (!act_ok || !chain_ok)
					next_state = `SSSC_ST_IDLE;
			end
			default: next_state = `SSSC_ST_IDLE;
		endcase
	end


	// ------------------------------------------------------------
	// State and safety outputs
	// ------------------------------------------------------------
	// Both channels drop together for the test pulse, so the pair never disagrees
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state             <= `SSSC_ST_IDLE;
			safety_out_chan_a <= 1'b0;
			safety_out_chan_b <= 1'b0;
			diag_signal_out   <= 1'b0;
		end else begin
			state             <= next_state;
			safety_out_chan_a <= is_on(next_state) & ~test_low;
			safety_out_chan_b <= is_on(next_state) & ~test_low;
			diag_signal_out   <= ~actuator_in_range;
		end
	end

	// ------------------------------------------------------------
	// Actuator link
	// ------------------------------------------------------------
	// Power and data follow presence alone; the coding check needs them running
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			actuator_power_en <= 1'b0;
			actuator_data_en  <= 1'b0;
		end else begin
			actuator_power_en <= actuator_in_range;
			actuator_data_en  <= actuator_in_range;
		end
	end
endmodule

/* verif/sssc_props.sv */
// Purpose: Port checks for the start control
// Assumes: One clock, async reset
// Notes:   Sees only the top module's ports
`timescale 1ns/1ps
module sssc_props (
	input wire sys_clk,
	input wire reset,
	input wire actuator_in_range,
	input wire safety_in_chan_a,
	input wire start_pin,
	input wire actuator_power_en,
	input wire actuator_data_en,
	input wire safety_out_chan_a,
	input wire safety_out_chan_b,
	input wire diag_signal_out,
	input wire auto_mode
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	chk_power_on: assert property (
		actuator_in_range |=> actuator_power_en) else $error("power late");
	chk_data_off: assert property (
		!actuator_in_range |=> !actuator_data_en) else $error("data stays on");
	chk_diag_leave: assert property (
		!actuator_in_range |=> diag_signal_out) else $error("diag late");
	chk_leave_off: assert property (
		!actuator_in_range |=> !safety_out_chan_a) else $error("outputs stay on");
	chk_chan_pair: assert property (
		safety_out_chan_a == safety_out_chan_b) else $error("channels differ");
	chk_rise_range: assert property (
		$rose(safety_out_chan_a) |-> $past(actuator_in_range)) else $error("on w/o actuator");
	chk_manual_fall: assert property (
		$rose(safety_out_chan_a) && !auto_mode |-> $past(!start_pin)) else $error("start early");
	chk_chain_off: assert property (
		!safety_in_chan_a [*3] |=> !safety_out_chan_a) else $error("chain ignored");
endmodule
bind sssc_start_ctrl sssc_props chk (.sys_clk, .reset, .actuator_in_range, .safety_in_chan_a,
	.start_pin, .actuator_power_en, .actuator_data_en, .safety_out_chan_a, .safety_out_chan_b,
	.diag_signal_out, .auto_mode);

/* verif/sssc_field.sv */
// Purpose: Start button, loopback bridge and chain feed
// Assumes: First switch of a chain
// Notes:   Loopback passes test pulses straight back
`timescale 1ns/1ps
module sssc_field (
	input  wire auto_sel,
	input  wire btn,
	input  wire chain_ok,
	input  wire safety_out_chan_a,
	output wire start_pin,
	output wire safety_in_chan_a,
	output wire safety_in_chan_b
);
	assign start_pin = auto_sel ? safety_out_chan_a : btn;
	assign safety_in_chan_a = chain_ok;
	assign safety_in_chan_b = chain_ok;
endmodule

/* verif/tb.sv */
// Purpose: Startup and output enable scenarios
// Assumes: Shortened start window 20..100 cycles
// Notes:   Output seen high at least once counts as on
`timescale 1ns/1ps
`define CMP(a, b) compares++; if ((a) !== (b)) begin n_errors++; \
	$display("unexpected at %0t: %h %h", $time, a, b); end
module tb;
	reg sys_clk = 0, reset = 1, actuator_in_range = 0, actuator_code_valid = 0;
	reg auto_sel = 0, btn = 0, chain_ok = 1, seen = 0;
	reg [2:0] q[$];
	reg [2:0] e;
	wire start_pin, safety_in_chan_a, safety_in_chan_b, actuator_power_en, actuator_data_en;
	wire safety_out_chan_a, safety_out_chan_b, diag_signal_out, auto_mode;
	integer n_errors = 0, compares = 0, seed = 32'h2bb2e1aa, i;
	event obs;
	initial forever #5 sys_clk = ~sys_clk;
	sssc_start_ctrl #(.START_MIN_CYC(20), .START_MAX_CYC(100), .PULSE_WIN_CYC(200),
		.TEST_PERIOD(50)) uut (.sys_clk, .reset, .actuator_in_range, .actuator_code_valid,
		.start_pin, .safety_in_chan_a, .safety_in_chan_b, .actuator_power_en,
		.actuator_data_en, .safety_out_chan_a, .safety_out_chan_b, .diag_signal_out, .auto_mode);
	sssc_field fld (.auto_sel, .btn, .chain_ok, .safety_out_chan_a, .start_pin,
		.safety_in_chan_a, .safety_in_chan_b);
	task run(input integer n); begin
		seen = 0;
		repeat (n) @(negedge sys_clk) seen = seen | safety_out_chan_a;
	end endtask
	task press(input integer n); begin
		btn = 1;
		repeat (n) @(negedge sys_clk);
		btn = 0;
	end endtask
	task expect_st(input [2:0] x); begin
		q.push_back(x);
		-> obs;
		#1;
	end endtask
	task summarize; begin
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	end endtask
	initial forever begin
		@obs;
		e = q.pop_front();
		`CMP({seen, diag_signal_out, auto_mode}, e)
	end
	initial begin
		repeat (2) @(negedge sys_clk);
		reset = 0;
		actuator_in_range = 1;
		actuator_code_valid = 1;
		run(30); expect_st(3'h0);
		press(10); run(30); expect_st(3'h0);
		press(150); run(30); expect_st(3'h0);
		press(22 + {$random(seed)} % 77); run(8); expect_st(3'h4);
		$display("manual start done");
		chain_ok = 0; run(3); run(10); expect_st(3'h0);
		chain_ok = 1; actuator_in_range = 0; run(3); run(20); expect_st(3'h2);
		actuator_in_range = 1; run(5); press(50); run(8); expect_st(3'h4);
		$display("leave and restart done");
		auto_sel = 1;
		for (i = 0; i < 2000 && auto_mode !== 1'b1; i++) @(negedge sys_clk);
		if (auto_mode !== 1'b1) begin
			n_errors++;
			$display("auto mode timeout");
		end else begin
			actuator_in_range = 0; run(3);
			actuator_in_range = 1; run(10); expect_st(3'h5);
			$display("auto start done");
		end
		summarize;
	end
endmodule
